// [acs_sequencer.sv]
// Purpose: APB-controlled sequencer for a 10-bit successive-approximation converter
// Assumes: Analog comparator and hold switch outside; i_comp_above asynchronous
// Notes:   One wait state on every APB access
// Function
// - Three-bit select picks system divide 2..64 or the RC oscillator
// - Bit period equals one conversion clock; conversion takes 11.5 periods
// - Divided clocks follow system clock rate; RC selection is independent
// - In Sleep only the RC selection advances a conversion
// - Software writing one to go starts the conversion sequence
// - Go reads one while converting and zero once finished
// - Flag with its own enable wakes from Sleep regardless of global enable
// - Right justified: top 2 bits high register, low 8 bits low register
// - Channel field routes the chosen input to the sample-and-hold
// - Reference fields pick pin or supply, pin or ground
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_sequencer (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_sleep,
    input  wire logic        i_rc_osc,
    input  wire logic        i_comp_above,
    output logic             o_converter_on,
    output logic [4:0]       o_channel_select,
    output logic             o_pos_ref_select,
    output logic             o_neg_ref_select,
    output logic             o_hold_connect,
    output logic [9:0]       o_trial_code,
    output logic             o_conv_irq,
    output logic             o_wake
);
    import acs_pkg::*;

    acs_state_t s_reg;
    acs_state_t s_next;
    logic       tad_tick;
    logic       acc_first;
    logic       done;
    logic       wr_go;
    logic [31:0] rdata;
    logic       rerr;
    logic [9:0] decided;

    acs_tad_gen u_tad (
        .i_clock        (i_clock),
        .i_rst_n        (i_rst_n),
        .i_run          (s_reg.phase == ACS_BUSY),
        .i_sleep        (i_sleep),
        .i_clock_select (s_reg.csel),
        .i_rc_osc       (i_rc_osc),
        .o_half_tick    (tad_tick)
    );

    // Bus phase decode and end-of-conversion strobe
    assign acc_first = i_psel && i_penable && !s_reg.pready;
    assign done = (s_reg.phase == ACS_BUSY) && tad_tick && (s_reg.hcnt == `ACS_HALF_LAST - 5'h01);
    assign wr_go = i_psel && i_penable && s_reg.pready && i_pwrite
                   && (i_paddr == `ACS_ADDR_CTRL_A) && i_pwdata[`ACS_A_GO];

    // Read mux; result layout depends on justification
    always_comb begin
        rdata = '0;
        rerr  = 1'b0;
        unique case (i_paddr)
            `ACS_ADDR_CTRL_A: begin
                rdata[`ACS_A_ON] = s_reg.on;
                rdata[`ACS_A_GO] = s_reg.go;
                rdata[`ACS_A_CHAN_HI:`ACS_A_CHAN_LO] = s_reg.channel_select;
            end
            `ACS_ADDR_CTRL_B: begin
                rdata[`ACS_B_PREF] = s_reg.pref;
                rdata[`ACS_B_NREF] = s_reg.nref;
                rdata[`ACS_B_CS_HI:`ACS_B_CS_LO] = s_reg.csel;
                rdata[`ACS_B_RJUST] = s_reg.rjust;
            end
            `ACS_ADDR_RES_HI: begin
                if (s_reg.rjust) begin
                    rdata[`ACS_RES_LOW_HI:0] = s_reg.result[`ACS_RES_MSB:`ACS_RES_SPLIT];
                end else begin
                    rdata[`ACS_BYTE_HI:0] = s_reg.result[`ACS_RES_MSB:`ACS_RES_LJ_LO];
                end
            end
            `ACS_ADDR_RES_LO: begin
                if (s_reg.rjust) begin
                    rdata[`ACS_BYTE_HI:0] = s_reg.result[`ACS_BYTE_HI:0];
                end else begin
                    rdata[`ACS_RES_LJ_LOW_HI:`ACS_RES_LJ_LOW_LO] =
                        s_reg.result[`ACS_RES_LOW_HI:0];
                end
            end
            `ACS_ADDR_IRQ: begin
                rdata[`ACS_I_FLAG] = s_reg.flag;
                rdata[`ACS_I_IE]   = s_reg.ie;
                rdata[`ACS_I_PIE]  = s_reg.pie;
                rdata[`ACS_I_GLOBAL_EN] = s_reg.global_irq_enable;
            end
            default: rerr = 1'b1;
        endcase
    end

    // Next state: bus writes first, then conversion so its set wins
    always_comb begin
        s_next = s_reg;
        decided = '0;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (acc_first) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = rerr;
            s_next.prdata  = i_pwrite ? 32'h0000_0000 : rdata;
        end
        if (i_psel && i_penable && s_reg.pready && i_pwrite) begin
            unique case (i_paddr)
                `ACS_ADDR_CTRL_A: begin
                    s_next.on  = i_pwdata[`ACS_A_ON];
                    s_next.channel_select = i_pwdata[`ACS_A_CHAN_HI:`ACS_A_CHAN_LO];
                    if (wr_go && s_next.on && s_reg.phase == ACS_IDLE) begin
                        s_next.go    = 1'b1;
                        s_next.phase = ACS_BUSY;
                        s_next.hcnt  = '0;
                    end else if (!i_pwdata[`ACS_A_GO] || !s_next.on) begin
                        // Clearing go or powering down abandons the conversion
                        s_next.go       = 1'b0;
                        s_next.phase    = ACS_IDLE;
                        s_next.cap_conn = 1'b1;
                    end
                end
                `ACS_ADDR_CTRL_B: begin
                    s_next.pref  = i_pwdata[`ACS_B_PREF];
                    s_next.nref  = i_pwdata[`ACS_B_NREF];
                    s_next.csel  = i_pwdata[`ACS_B_CS_HI:`ACS_B_CS_LO];
                    s_next.rjust = i_pwdata[`ACS_B_RJUST];
                end
                `ACS_ADDR_IRQ: begin
                    if (i_pwdata[`ACS_I_FLAG]) begin
                        s_next.flag = 1'b0;
                    end
                    s_next.ie  = i_pwdata[`ACS_I_IE];
                    s_next.pie = i_pwdata[`ACS_I_PIE];
                    s_next.global_irq_enable = i_pwdata[`ACS_I_GLOBAL_EN];
                end
                default: s_next.pslverr = 1'b0;
            endcase
        end
        // Comparator: three stages, level taken once stages two and three agree
        s_next.csync = {s_reg.csync[1:0], i_comp_above};
        if (s_reg.csync[2] == s_reg.csync[1]) begin
            s_next.comp = s_reg.csync[2];
        end
        // Successive approximation paced by half-period ticks
        if (s_reg.phase == ACS_BUSY && tad_tick) begin
            s_next.hcnt = s_reg.hcnt + 5'h01;
            if (s_next.hcnt == `ACS_HALF_DISC) begin
                s_next.cap_conn = 1'b0;
            end else if (s_next.hcnt == `ACS_HALF_FIRST) begin
                s_next.mask  = `ACS_MSB_MASK;
                s_next.trial = `ACS_MSB_MASK;
            end else if (s_next.hcnt[0] && s_next.hcnt > `ACS_HALF_FIRST) begin
                // Keep the trial bit only when the input is above the trial level
                decided = s_reg.comp ? s_reg.trial : (s_reg.trial & ~s_reg.mask);
                s_next.mask  = s_reg.mask >> 1;
                s_next.trial = decided | s_next.mask;
                if (s_next.hcnt == `ACS_HALF_LAST) begin
                    s_next.result   = decided;
                    s_next.go       = 1'b0;
                    s_next.flag     = 1'b1;
                    s_next.cap_conn = 1'b1;
                    s_next.phase    = ACS_IDLE;
                end
            end
        end
        // Idle keeps the capacitor on the input, even when an abort meets a tick
        if (s_next.phase == ACS_IDLE) begin
            s_next.cap_conn = 1'b1;
        end
        // Wake needs only the converter enable; vectoring needs all three
        s_next.irq  = s_next.flag && s_next.ie && s_next.pie && s_next.global_irq_enable;
        s_next.wake = s_next.flag && s_next.ie;
    end

    // State register; capacitor connected while idle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
            s_reg.cap_conn <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_prdata         = s_reg.prdata;
    assign o_pready         = s_reg.pready;
    assign o_pslverr        = s_reg.pslverr;
    assign o_converter_on   = s_reg.on;
    assign o_channel_select = s_reg.channel_select;
    assign o_pos_ref_select = s_reg.pref;
    assign o_neg_ref_select = s_reg.nref;
    assign o_hold_connect   = s_reg.cap_conn;
    assign o_trial_code     = s_reg.trial;
    assign o_conv_irq       = s_reg.irq;
    assign o_wake           = s_reg.wake;

    // Checks
    sequence start_s;
        wr_go && s_reg.on && i_pwdata[`ACS_A_ON] && s_reg.phase == ACS_IDLE;
    endsequence
    sequence sleep_div_s;
        (i_sleep && s_reg.csel[1:0] != `ACS_CS_RC_BITS && s_reg.phase == ACS_BUSY) [*2];
    endsequence
    sequence div4_s;
        (!i_sleep && s_reg.csel == `ACS_CS_DIV4 && s_reg.phase == ACS_BUSY) [*3];
    endsequence

    go_start_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        start_s |=> s_reg.go && s_reg.phase == ACS_BUSY)
        else $error("go write did not start a conversion");
    go_busy_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_reg.phase == ACS_BUSY |-> s_reg.go)
        else $error("go low during conversion");
    end_load_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        done |=> !s_reg.go && s_reg.flag && s_reg.cap_conn && s_reg.phase == ACS_IDLE)
        else $error("end of conversion actions missing");
    disc_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_reg.phase == ACS_BUSY && tad_tick && s_reg.hcnt == '0 |=> !s_reg.cap_conn)
        else $error("capacitor not disconnected on first half period");
    sleep_stall_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        sleep_div_s |-> !tad_tick)
        else $error("divided clock advanced in sleep");
    div4_rate_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        div4_s ##0 tad_tick |-> !$past(tad_tick))
        else $error("divide by four ticked too fast");
    wake_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_reg.flag && s_reg.ie && !s_reg.global_irq_enable |-> s_reg.wake)
        else $error("no wake with converter enable");
    rjust_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        acc_first && !i_pwrite && i_paddr == `ACS_ADDR_RES_HI && s_reg.rjust
        |=> (o_prdata >> (`ACS_RES_LOW_HI + 1)) == '0
        && o_prdata[`ACS_RES_LOW_HI:0] == s_reg.result[`ACS_RES_MSB:`ACS_RES_SPLIT])
        else $error("right justified high result wrong");
    flag_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_reg.flag && !(i_psel && i_penable && s_reg.pready && i_pwrite
        && i_paddr == `ACS_ADDR_IRQ) |=> s_reg.flag)
        else $error("flag cleared without software");
endmodule

// [acs_consts.svh]
// Purpose: Named constants for the conversion sequencer
// Assumes: 12-bit APB byte address, 32-bit data
// Notes:   Definitions only
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// Register byte addresses
`define ACS_ADDR_CTRL_A   12'h000
`define ACS_ADDR_CTRL_B   12'h004
`define ACS_ADDR_RES_HI   12'h008
`define ACS_ADDR_RES_LO   12'h00C
`define ACS_ADDR_IRQ      12'h010
// Control A fields
`define ACS_A_ON          0
`define ACS_A_GO          1
`define ACS_A_CHAN_LO     2
`define ACS_A_CHAN_HI     6
// Control B fields
`define ACS_B_PREF        0
`define ACS_B_NREF        1
`define ACS_B_CS_LO       4
`define ACS_B_CS_HI       6
`define ACS_B_RJUST       7
// Interrupt control fields
`define ACS_I_FLAG        0
`define ACS_I_IE          1
`define ACS_I_PIE         2
`define ACS_I_GLOBAL_EN   3
// Result layout
`define ACS_RES_MSB       9
`define ACS_RES_SPLIT     8
`define ACS_RES_LJ_LO     2
`define ACS_RES_LJ_LOW_HI 7
`define ACS_RES_LJ_LOW_LO 6
`define ACS_RES_LOW_HI    1
`define ACS_BYTE_HI       7
`define ACS_MSB_MASK      10'h200
// Clock select codes and half-period reload counts
`define ACS_CS_DIV2       3'h0
`define ACS_CS_DIV4       3'h4
`define ACS_CS_DIV8       3'h1
`define ACS_CS_DIV16      3'h5
`define ACS_CS_DIV32      3'h2
`define ACS_CS_DIV64      3'h6
`define ACS_CS_RC_BITS    2'h3
`define ACS_LIM_DIV2      6'h00
`define ACS_LIM_DIV4      6'h01
`define ACS_LIM_DIV8      6'h03
`define ACS_LIM_DIV16     6'h07
`define ACS_LIM_DIV32     6'h0F
`define ACS_LIM_DIV64     6'h1F
// Half-period milestones of one conversion (23 halves = 11.5 periods)
`define ACS_HALF_DISC     5'h01
`define ACS_HALF_FIRST    5'h03
`define ACS_HALF_LAST     5'h17
`endif

// [acs_pkg.sv]
// Purpose: Types shared by the conversion sequencer files
// Assumes: Constants come from acs_consts.svh
// Notes:   Whole state of each design module is one packed struct
package acs_pkg;
    typedef enum logic [0:0] {
        ACS_IDLE = 1'b0,
        ACS_BUSY = 1'b1
    } acs_phase_t;

    typedef struct packed {
        logic       pready;
        logic       pslverr;
        logic [31:0] prdata;
        logic       on;
        logic       go;
        logic [4:0] channel_select;
        logic       rjust;
        logic [2:0] csel;
        logic       pref;
        logic       nref;
        logic [9:0] result;
        logic       flag;
        logic       ie;
        logic       pie;
        logic       global_irq_enable;
        logic       irq;
        logic       wake;
        acs_phase_t phase;
        logic [4:0] hcnt;
        logic [9:0] trial;
        logic [9:0] mask;
        logic       cap_conn;
        logic [2:0] csync;
        logic       comp;
    } acs_state_t;

    typedef struct packed {
        logic [5:0] cnt;
        logic [2:0] sync;
        logic       rc_level;
        logic       tick;
    } acs_tad_state_t;
endpackage

// [acs_tad_gen.sv]
// Purpose: Half-period tick source for the conversion clock
// Assumes: RC oscillator arrives asynchronously on i_rc_osc
// Notes:   One tick per half conversion-clock period
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_tad_gen (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_run,
    input  wire logic       i_sleep,
    input  wire logic [2:0] i_clock_select,
    input  wire logic       i_rc_osc,
    output logic            o_half_tick
);
    import acs_pkg::*;

    acs_tad_state_t s_reg;
    acs_tad_state_t s_next;
    logic [5:0]     limit;
    logic           use_rc;

    // Divider reload per select code
    always_comb begin
        use_rc = (i_clock_select[1:0] == `ACS_CS_RC_BITS);
        unique case (i_clock_select)
            `ACS_CS_DIV2:  limit = `ACS_LIM_DIV2;
            `ACS_CS_DIV4:  limit = `ACS_LIM_DIV4;
            `ACS_CS_DIV8:  limit = `ACS_LIM_DIV8;
            `ACS_CS_DIV16: limit = `ACS_LIM_DIV16;
            `ACS_CS_DIV32: limit = `ACS_LIM_DIV32;
            `ACS_CS_DIV64: limit = `ACS_LIM_DIV64;
            default:       limit = `ACS_LIM_DIV64;
        endcase
    end

    // Tick from divided system clock or from RC edges
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        s_next.sync = {s_reg.sync[1:0], i_rc_osc};
        // RC level counts once second and third stage agree
        if (s_reg.sync[2] == s_reg.sync[1]) begin
            s_next.rc_level = s_reg.sync[2];
        end
        if (!i_run) begin
            s_next.cnt = '0;
        end else if (use_rc) begin
            s_next.cnt = '0;
            // Both RC edges are half periods; independent of system rate
            s_next.tick = (s_next.rc_level != s_reg.rc_level);
        end else if (i_sleep) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt >= limit) begin
            // Counting system cycles makes the period track its rate
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 6'h01;
        end
    end

    // State register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_half_tick = s_reg.tick;
endmodule

// [acs_sequencer_tb.sv]
// Purpose: Self-checking bench for the conversion sequencer over APB
// Assumes: One wait state per access; comparator held constant per run
// Notes:   RC oscillator toggles every 4 system cycles and runs freely
`timescale 1ns/1ps
`include "acs_consts.svh"
module acs_sequencer_tb;
    logic        i_clock;
    logic        i_rst_n;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        i_sleep;
    logic        i_rc_osc;
    logic        i_comp_above;
    logic        o_converter_on;
    logic [4:0]  o_channel_select;
    logic        o_pos_ref_select;
    logic        o_neg_ref_select;
    logic        o_hold_connect;
    logic [9:0]  o_trial_code;
    logic        o_conv_irq;
    logic        o_wake;
    logic [31:0] rd;
    logic        err;
    logic [31:0] span;
    logic [1:0]  rc_cnt;
    time         t_dis;
    int          miscompares;
    int          cmp_count;

    acs_sequencer dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sleep(i_sleep), .i_rc_osc(i_rc_osc),
        .i_comp_above(i_comp_above), .o_converter_on(o_converter_on),
        .o_channel_select(o_channel_select), .o_pos_ref_select(o_pos_ref_select),
        .o_neg_ref_select(o_neg_ref_select), .o_hold_connect(o_hold_connect),
        .o_trial_code(o_trial_code), .o_conv_irq(o_conv_irq), .o_wake(o_wake)
    );

    // 20 MHz system clock
    always #25 i_clock = ~i_clock;

    // RC oscillator stand-in, same half period (4 system cycles) as the divide-by-8 selection
    always @(posedge i_clock) begin
        rc_cnt <= rc_cnt + 2'd1;
        if (rc_cnt == 2'd3) begin
            i_rc_osc <= ~i_rc_osc;
        end
    end

    // Disconnect span of the hold capacitor, in system cycles
    always @(negedge o_hold_connect) begin
        t_dis = $time;
    end
    always @(posedge o_hold_connect) begin
        span = 32'(($time - t_dis) / 50);
    end

    // Single comparison; case equality so unknowns never match
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // APB transfer: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clock);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready timeout", 32'h0000_0001, 32'h0000_0000);
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // Poll go until it reads zero, bounded
    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, `ACS_ADDR_CTRL_A, 32'h0000_0000);
            n++;
        end while (rd[1] === 1'b1 && n < 3000);
        chk("go done", 32'h0000_0000, {31'b0, rd[1]});
    endtask

    // Full conversion on channel 0x15, then result, flag and clear checks
    task automatic run_conv(input logic [7:0] b, input int div, input logic [7:0] hi,
                            input logic [7:0] lo, input logic irq_e);
        span = 'x;
        apb(1'b1, `ACS_ADDR_CTRL_B, {24'h00_0000, b});
        apb(1'b1, `ACS_ADDR_CTRL_A, 32'h0000_0055);
        // Acquisition time after power-up and channel choice, before go
        repeat (4) @(posedge i_clock);
        chk("converter on", 32'h0000_0001, {31'b0, o_converter_on});
        apb(1'b1, `ACS_ADDR_CTRL_A, 32'h0000_0057);
        apb(1'b0, `ACS_ADDR_CTRL_A, 32'h0000_0000);
        chk("go busy", 32'h0000_0001, {31'b0, rd[1]});
        chk("channel", 32'h0000_0015, {27'b0, o_channel_select});
        wait_done();
        if (div > 0) begin
            chk("span", 32'(div * 11), span);
        end
        apb(1'b0, `ACS_ADDR_RES_HI, 32'h0000_0000);
        chk("result high", {24'h00_0000, hi}, rd);
        apb(1'b0, `ACS_ADDR_RES_LO, 32'h0000_0000);
        chk("result low", {24'h00_0000, lo}, rd);
        apb(1'b0, `ACS_ADDR_IRQ, 32'h0000_0000);
        chk("flag set", 32'h0000_0001, {31'b0, rd[0]});
        chk("hold back", 32'h0000_0001, {31'b0, o_hold_connect});
        chk("wake", 32'h0000_0001, {31'b0, o_wake});
        chk("irq", {31'b0, irq_e}, {31'b0, o_conv_irq});
        apb(1'b1, `ACS_ADDR_IRQ, rd);
        apb(1'b0, `ACS_ADDR_IRQ, 32'h0000_0000);
        chk("flag clear", 32'h0000_0000, {31'b0, rd[0]});
    endtask

    // Single exit point of the run
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog: about twenty-five times the expected run length
    initial begin
        #3_000_000;
        miscompares++;
        wrap_up();
    end

    // Main sequence
    initial begin
        logic [2:0] cs_tab [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
        int         dv_tab [6] = '{2, 4, 8, 16, 32, 64};
        i_clock = 0;
        i_rst_n = 0;
        i_psel = 0;
        i_penable = 0;
        i_pwrite = 0;
        i_paddr = '0;
        i_pwdata = '0;
        i_sleep = 0;
        i_rc_osc = 0;
        i_comp_above = 0;
        rc_cnt = '0;
        miscompares = 0;
        cmp_count = 0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(negedge i_clock);
        chk("reset hold", 32'h0000_0001, {31'b0, o_hold_connect});
        chk("reset on", 32'h0000_0000, {31'b0, o_converter_on});
        apb(1'b0, `ACS_ADDR_CTRL_A, 32'h0000_0000);
        chk("ctrl a reset", 32'h0000_0000, rd);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'b0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        // Every divided selection, right justified, all bits kept
        apb(1'b1, `ACS_ADDR_IRQ, 32'h0000_0002);
        i_comp_above <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            run_conv({1'b1, cs_tab[i], 4'h0}, dv_tab[i], 8'h03, 8'hFF, 1'b0);
        end
        // Comparator always above: every trial bit kept, code ends all ones
        chk("trial code", 32'h0000_03FF, {22'b0, o_trial_code});
        // Left justified with all enables and both references
        apb(1'b1, `ACS_ADDR_IRQ, 32'h0000_000E);
        run_conv(8'h03, 2, 8'hFF, 8'hC0, 1'b1);
        chk("pos ref", 32'h0000_0001, {31'b0, o_pos_ref_select});
        chk("neg ref", 32'h0000_0001, {31'b0, o_neg_ref_select});
        // Both RC codes during Sleep, comparator low
        apb(1'b1, `ACS_ADDR_IRQ, 32'h0000_0002);
        i_comp_above <= 1'b0;
        i_sleep <= 1'b1;
        run_conv(8'hB0, 0, 8'h00, 8'h00, 1'b0);
        run_conv(8'hF0, 0, 8'h00, 8'h00, 1'b0);
        // Divided clock stalls in Sleep until it ends
        apb(1'b1, `ACS_ADDR_CTRL_B, 32'h0000_0080);
        apb(1'b1, `ACS_ADDR_CTRL_A, 32'h0000_0003);
        repeat (60) @(posedge i_clock);
        apb(1'b0, `ACS_ADDR_CTRL_A, 32'h0000_0000);
        chk("sleep stall", 32'h0000_0001, {31'b0, rd[1]});
        i_sleep <= 1'b0;
        wait_done();
        apb(1'b1, `ACS_ADDR_IRQ, 32'h0000_0003);
        // Abort by clearing go in mid-conversion
        apb(1'b1, `ACS_ADDR_CTRL_B, 32'h0000_00E0);
        apb(1'b1, `ACS_ADDR_CTRL_A, 32'h0000_0003);
        repeat (20) @(posedge i_clock);
        apb(1'b1, `ACS_ADDR_CTRL_A, 32'h0000_0001);
        apb(1'b0, `ACS_ADDR_CTRL_A, 32'h0000_0000);
        chk("abort go", 32'h0000_0000, {31'b0, rd[1]});
        chk("abort hold", 32'h0000_0001, {31'b0, o_hold_connect});
        apb(1'b0, `ACS_ADDR_IRQ, 32'h0000_0000);
        chk("abort flag", 32'h0000_0000, {31'b0, rd[0]});
        // Result registers ignore writes
        apb(1'b1, `ACS_ADDR_RES_LO, 32'h0000_00FF);
        chk("res wr err", 32'h0000_0000, {31'b0, err});
        apb(1'b0, `ACS_ADDR_RES_LO, 32'h0000_0000);
        chk("res kept", 32'h0000_0000, rd);
        wrap_up();
    end
endmodule
